/* File: rtl/pa_seq_pkg.sv */
// shared constants and state types for the amplifier enable sequencer
package pa_seq_pkg;

    // clock rate in MHz
    localparam real CLK_MHZ = 125.0;

    // delays as specified, in microseconds
    localparam real TX_ON_DELAY_US = 62.5;   // receive select fall to amp enable
    localparam real RECAL_DELAY_US = 6.5;    // receive select rise to recalibration
    localparam real RX_READY_US = 70.0;      // receive select rise to receive mode
    localparam real AMP_OFF_MAX_US = 0.1;    // receive select rise to amp off, longest

    // least times round up, longest times round down
    localparam int TX_ON_CYCLES = int'($ceil(TX_ON_DELAY_US * CLK_MHZ));
    localparam int RECAL_CYCLES = int'($ceil(RECAL_DELAY_US * CLK_MHZ));
    localparam int RX_READY_CYCLES = int'($ceil(RX_READY_US * CLK_MHZ));
    localparam int AMP_OFF_CYCLES = int'($floor(AMP_OFF_MAX_US * CLK_MHZ));

    // width of delay counters
    localparam int TIMER_W = 16;

    // reset values
    localparam logic RX_SEL_RESET = 1'b1;    // receive assumed at reset
    localparam logic [TIMER_W-1:0] CNT_RESET = 16'h0000;

    // delay timer state
    typedef struct packed {
        logic busy;                 // counting
        logic done;                 // expiry pulse
        logic [TIMER_W-1:0] cnt;    // cycles left
    } timer_s;

    // sequencer state
    typedef struct packed {
        logic rx_q;                 // last sampled receive select
        logic tx_armed;             // transmit delay expired in this slot
        logic fault;                // latched lock or supply fault
        logic amp;                  // amplifier enable
        logic recal;                // recalibration start pulse
        logic rx_ready;             // fully in receive mode
        logic [TIMER_W-1:0] since;  // cycles since last edge, saturating
    } seq_s;

endpackage

/* File: rtl/delay_timer_if.sv */
// start, stop and expiry signals between the sequencer and one delay timer
`timescale 1ns/1ps
interface delay_timer_if;
    logic start;   // begin a fresh delay
    logic stop;    // abandon the delay
    logic done;    // one-cycle expiry pulse

    modport ctrl (output start, output stop, input done);
    modport tmr (input start, input stop, output done);
endinterface

/* File: rtl/delay_timer.sv */
// one-shot delay timer giving a pulse a fixed number of cycles after start
`timescale 1ns/1ps
module delay_timer
    import pa_seq_pkg::*;
#(
    parameter int COUNT = 16
) (
    // clock and reset
    input logic clk_sys_in,
    input logic resetn_in,
    // control
    delay_timer_if.tmr port
);

    timer_s st;        // registered state
    timer_s next_st;   // next state

    ////////////////////////////////////////////////////////////////////////
    // next state: load, count down, pulse at zero
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (port.stop) begin
            // abandon any delay in flight
            next_st.busy = 1'b0;
            next_st.cnt = CNT_RESET;
        end else if (port.start) begin
            // restart from the full count
            next_st.busy = 1'b1;
            next_st.cnt = TIMER_W'(COUNT - 1);
        end else if (st.busy) begin
            if (st.cnt == CNT_RESET) begin
                // expiry
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.done = st.done;

endmodule

/* File: rtl/pa_enable_sequencer.sv */
// amplifier enable sequencer following the receive select input
`timescale 1ns/1ps
module pa_enable_sequencer
    import pa_seq_pkg::*;
#(
    parameter int TX_ON_COUNT = TX_ON_CYCLES,     // fall to amp enable, cycles
    parameter int RX_READY_COUNT = RX_READY_CYCLES // rise to receive mode, cycles
) (
    // clock and reset
    input logic clk_sys_in,
    input logic resetn_in,
    // baseband control
    input logic receive_select_in,
    // analog monitors
    input logic pll_locked_in,
    input logic supply_low_in,
    // amplifier and sequencing outputs
    output logic amp_enable_out,
    output logic recal_start_out,
    output logic receive_ready_out,
    output logic fault_latched_out
);

    seq_s st;          // registered state
    seq_s next_st;     // next state
    logic rise;        // select rising: slot ends
    logic fall;        // select falling: slot starts
    logic fault_now;   // live fault from monitors

    // bound of the drop window, held here as a plain int for the check
    localparam int AMP_OFF_LIMIT = AMP_OFF_CYCLES;

    delay_timer_if tx_tmr ();     // fall to amp enable
    delay_timer_if recal_tmr ();  // rise to recalibration
    delay_timer_if ready_tmr ();  // rise to receive mode

    ////////////////////////////////////////////////////////////////////////
    // delay timers
    delay_timer #(.COUNT(TX_ON_COUNT)) u_tx_tmr (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .port(tx_tmr.tmr)
    );

    delay_timer #(.COUNT(RECAL_CYCLES)) u_recal_tmr (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .port(recal_tmr.tmr)
    );

    delay_timer #(.COUNT(RX_READY_COUNT)) u_ready_tmr (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .port(ready_tmr.tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge detection and timer control
    assign rise = receive_select_in & ~st.rx_q;
    assign fall = ~receive_select_in & st.rx_q;
    assign fault_now = ~pll_locked_in | supply_low_in;

    // transmit delay runs from slot start, abandoned at slot end
    assign tx_tmr.start = fall;
    assign tx_tmr.stop = rise;
    // receive-side delays run from slot end, abandoned if a slot starts
    assign recal_tmr.start = rise;
    assign recal_tmr.stop = fall;
    assign ready_tmr.start = rise;
    assign ready_tmr.stop = fall;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.rx_q = receive_select_in;
        // transmit arming: set by delay expiry inside the slot only
        if (rise || fall) begin
            next_st.tx_armed = 1'b0;
        end else if (tx_tmr.done && !receive_select_in) begin
            next_st.tx_armed = 1'b1;
        end
        // fault latch: cleared at slot end, set only inside a slot
        if (rise) begin
            next_st.fault = 1'b0;
        end
        if (!receive_select_in && fault_now) begin
            next_st.fault = 1'b1;
        end
        // amp enable: in slot, delay done, no live or latched fault
        next_st.amp = ~receive_select_in & next_st.tx_armed & ~next_st.fault;
        // recalibration pulse on timer expiry while receiving
        next_st.recal = recal_tmr.done & receive_select_in;
        // receive mode level
        if (fall) begin
            next_st.rx_ready = 1'b0;
        end else if (ready_tmr.done && receive_select_in) begin
            next_st.rx_ready = 1'b1;
        end
        // cycles since the last select edge, saturating
        if (rise || fall) begin
            next_st.since = CNT_RESET;
        end else if (st.since != {TIMER_W{1'b1}}) begin
            next_st.since = st.since + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
            st.rx_q <= RX_SEL_RESET;
            st.since <= CNT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign amp_enable_out = st.amp;
    assign recal_start_out = st.recal;
    assign receive_ready_out = st.rx_ready;
    assign fault_latched_out = st.fault;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // enable only follows a low select and a clean cycle
    a_amp_in_slot: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        amp_enable_out |-> !$past(receive_select_in) && !$past(fault_now) && st.tx_armed)
        else $error("amp enable high outside armed fault-free slot");

    a_amp_on_delay: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        $rose(amp_enable_out) && !$past(st.fault) |-> int'(st.since) == TX_ON_COUNT + 1)
        else $error("amp enable rose at wrong delay after select fell");

    a_amp_never_early: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        amp_enable_out |-> int'(st.since) > TX_ON_COUNT)
        else $error("amp enable before transmit delay");

    a_recal_delay: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        recal_start_out |-> st.rx_q && int'(st.since) == RECAL_CYCLES + 1)
        else $error("recalibration pulse at wrong delay");

    a_rx_ready_delay: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        $rose(receive_ready_out) |-> int'(st.since) == RX_READY_COUNT + 1)
        else $error("receive mode reached at wrong delay");

    a_amp_off_fast: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        rise |-> ##[1:AMP_OFF_LIMIT] !amp_enable_out)
        else $error("amp enable not dropped after select rose");

    a_fault_blocks: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        fault_now |=> !amp_enable_out)
        else $error("amp enable high during live fault");

    a_fault_holds: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (!receive_select_in && fault_now) ##1 !receive_select_in [*2]
        |-> fault_latched_out && !amp_enable_out)
        else $error("fault latch lost inside slot");

    a_fault_clear: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        rise |=> !fault_latched_out)
        else $error("fault latch not cleared at slot end");

    // enable falls on the cycle after a rise is seen
    a_amp_drop_next: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        rise |=> !amp_enable_out)
        else $error("amp enable still high one cycle after select rose");

    // a running enable keeps running while the slot stays clean
    a_amp_stays_on: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        amp_enable_out && !receive_select_in && !fault_now |=> amp_enable_out)
        else $error("amp enable dropped inside a clean slot");

    // lock loss inside a slot is latched on the next edge
    a_lock_latched: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !receive_select_in && !pll_locked_in |=> fault_latched_out)
        else $error("lock loss in slot not latched");

    // low supply inside a slot is latched on the next edge
    a_supply_latched: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !receive_select_in && supply_low_in |=> fault_latched_out)
        else $error("low supply in slot not latched");

    // nothing stays latched while receiving
    a_fault_rx_clear: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        receive_select_in |=> !fault_latched_out)
        else $error("fault latch set outside a slot");

    // recalibration start is a single-cycle pulse
    a_recal_pulse: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        recal_start_out |=> !recal_start_out)
        else $error("recalibration pulse longer than one cycle");

    // receive mode ends as soon as a slot starts
    a_ready_drop: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        fall |=> !receive_ready_out)
        else $error("receive mode kept after select fell");

    // receive mode holds while select stays high
    a_ready_holds: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        receive_ready_out && receive_select_in |=> receive_ready_out)
        else $error("receive mode lost while select high");

    // receive mode and transmit never overlap
    a_ready_no_amp: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        receive_ready_out |-> !amp_enable_out)
        else $error("amp enable high in receive mode");

endmodule

/* File: dv/pa_model.sv */
// amplifier model that tracks how long its enable is held
`timescale 1ns/1ps
module pa_model (
    // clock and reset
    input logic clk_sys_in,
    input logic resetn_in,
    // enable from the sequencer
    input logic amp_enable_in,
    // powered cycles since switch-on, and since reset
    output int on_cycles_out,
    output int total_out
);
    ////////////////////////////////////////////////////////////
    // count powered cycles, restart the run count at switch-off
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            on_cycles_out <= 0;
            total_out <= 0;
        end else if (amp_enable_in) begin
            on_cycles_out <= on_cycles_out + 1;
            total_out <= total_out + 1;
        end else begin
            on_cycles_out <= 0;
        end
    end
endmodule

/* File: dv/pa_enable_sequencer_test.sv */
// self-checking bench for the amplifier enable sequencer
`timescale 1ns/1ps
module pa_enable_sequencer_test;
    import pa_seq_pkg::*;
    localparam int TX_N = 20;  // shortened transmit delay
    localparam int RX_N = 30;  // shortened receive delay
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic receive_select_in = 1'b1;  // receive at start
    logic pll_locked_in = 1'b1;
    logic supply_low_in = 1'b0;
    logic amp_enable_out;
    logic recal_start_out;
    logic receive_ready_out;
    logic fault_latched_out;
    int on_cycles;
    int total_on;
    int n_errors = 0;
    int comparisons = 0;
    int at = 0;  // edges since last select change
    int t0;
    ////////////////////////////////////////////////////////////
    // clock and instances
    always #4 clk_sys_in = ~clk_sys_in;
    pa_enable_sequencer #(.TX_ON_COUNT(TX_N), .RX_READY_COUNT(RX_N)) uut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .receive_select_in(receive_select_in), .pll_locked_in(pll_locked_in),
        .supply_low_in(supply_low_in), .amp_enable_out(amp_enable_out),
        .recal_start_out(recal_start_out), .receive_ready_out(receive_ready_out),
        .fault_latched_out(fault_latched_out));
    pa_model model (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .amp_enable_in(amp_enable_out), .on_cycles_out(on_cycles), .total_out(total_on));
    ////////////////////////////////////////////////////////////
    // helpers: select change, wait to edge n after it, compare
    task automatic set_sel(input logic v);
        @(posedge clk_sys_in);
        receive_select_in <= v;
        at = 0;
    endtask
    task automatic upto(input int n);
        repeat (n - at) @(posedge clk_sys_in);
        #1;
        at = n;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic fault_pulse(input logic on_pll);
        @(posedge clk_sys_in);
        if (on_pll) begin
            pll_locked_in <= 1'b0;
        end else begin
            supply_low_in <= 1'b1;
        end
        @(posedge clk_sys_in);
        #1;
        chk(amp_enable_out, 1'b0, "amp during fault");
        @(posedge clk_sys_in);
        pll_locked_in <= 1'b1;
        supply_low_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        at = at + 4;
    endtask
    ////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_transmit;
        set_sel(1'b0);
        upto(TX_N + 1);
        chk(amp_enable_out, 1'b0, "amp early");
        chk(receive_ready_out, 1'b0, "ready in slot");
        upto(TX_N + 2);
        chk(amp_enable_out, 1'b1, "amp late");
    endtask
    task automatic t_receive;
        set_sel(1'b1);
        upto(1);
        chk(amp_enable_out, 1'b0, "amp not dropped");
        upto(RX_N + 1);
        chk(receive_ready_out, 1'b0, "ready early");
        upto(RX_N + 2);
        chk(receive_ready_out, 1'b1, "ready late");
        fault_pulse(1'b1);
        chk(fault_latched_out, 1'b0, "fault latched in receive");
        upto(RECAL_CYCLES + 1);
        chk(recal_start_out, 1'b0, "recal early");
        upto(RECAL_CYCLES + 2);
        chk(recal_start_out, 1'b1, "recal missing");
        upto(RECAL_CYCLES + 3);
        chk(recal_start_out, 1'b0, "recal too long");
    endtask
    task automatic t_fault;
        set_sel(1'b0);
        upto(1);
        chk(receive_ready_out, 1'b0, "ready kept in slot");
        upto(TX_N + 3);
        chk(amp_enable_out, 1'b1, "amp before fault");
        fault_pulse(1'b1);
        upto(TX_N + 12);
        chk(amp_enable_out, 1'b0, "amp after fault gone");
        chk(fault_latched_out, 1'b1, "latch lost");
        set_sel(1'b1);
        upto(1);
        chk(fault_latched_out, 1'b0, "latch kept at slot end");
        set_sel(1'b0);
        fault_pulse(1'b0);
        upto(TX_N + 3);
        chk(amp_enable_out, 1'b0, "amp on low supply");
        chk(fault_latched_out, 1'b1, "supply fault not latched");
        set_sel(1'b1);
        set_sel(1'b0);
        upto(TX_N + 1);
        chk(amp_enable_out, 1'b0, "amp early after fault");
        upto(TX_N + 2);
        chk(amp_enable_out, 1'b1, "no transmit after fault");
    endtask
    task automatic t_reset;
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        receive_select_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(amp_enable_out, 1'b0, "amp in reset");
        @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        at = 0;
        upto(TX_N + 1);
        chk(amp_enable_out, 1'b0, "amp early after reset");
        upto(TX_N + 2);
        chk(amp_enable_out, 1'b1, "amp late after reset");
    endtask
    task automatic t_abort;
        set_sel(1'b1);
        upto(3);
        t0 = total_on;
        set_sel(1'b0);
        upto(TX_N);
        set_sel(1'b1);
        upto(TX_N + 10);
        chk(total_on == t0, 1'b1, "amp on in cut slot");
        chk(on_cycles == 0, 1'b1, "amp still powered");
    endtask
    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk(amp_enable_out, 1'b0, "amp after reset");
        chk(fault_latched_out, 1'b0, "latch after reset");
        t_transmit();
        t_receive();
        t_fault();
        t_reset();
        t_abort();
        test_done();
    end
    // watchdog well past the expected run
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors++;
        test_done();
    end
endmodule
